// >>> dpir_host_model.sv
// Purpose: host side of the two interrupt lines
// Assumes: first line has a pull-up, second line has none
// Notes: an undriven second line toggles so a stale level never passes
`timescale 1ns/1ns
module dpir_host_model
(
    // clock
    input wire logic sys_clk,
    // pins from the device
    input wire logic first_o,
    input wire logic first_oe_n,
    input wire logic second_o,
    input wire logic second_oe_n,
    // host view, active low
    output logic line_first_n,
    output logic line_second_n
);
    // ------------------------------------------------------------
    // line resolution
    // ------------------------------------------------------------
    logic float_q = 1'b0;

    always @(posedge sys_clk)
    begin
        float_q <= ~float_q;
    end

    // pull-up wins only while the open-drain pin lets go
    assign line_first_n = first_oe_n ? 1'b1 : first_o;
    assign line_second_n = second_oe_n ? float_q : second_o;
endmodule

// >>> dpir_pin_gen.sv
// Purpose: one interrupt pin generator, pulse or level style
// Assumes: events are one-cycle strobes, flags are levels
// Notes: output is active high here; top inverts for the pin
`timescale 1ns/1ns
module dpir_pin_gen
    import dpir_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic [7:0] enables,
    input wire logic release_tick,
    // sources
    input dpir_pkg::dpir_src_type events,
    input dpir_pkg::dpir_flag_type flags,
    // output
    output logic irq_active
);
    import dpir_pkg::*;

    typedef struct packed {
        logic pulse;
        logic [1:0] ticks;
    } dpir_pin_state_type;

    dpir_pin_state_type s_q;
    dpir_pin_state_type s_d;
    logic trig;
    logic flag_any;
    logic trig_src_flagged;
    logic src_flag_clear;

    // gating by per-pin enable bits
    always_comb
    begin
        trig = (events.tick & enables[DPIR_BIT_TICK])
            | (events.trim & enables[DPIR_BIT_TRIM])
            | (events.alarm_one & enables[DPIR_BIT_ALARM_ONE])
            | (events.alarm_two & enables[DPIR_BIT_ALARM_TWO])
            | (events.stamp & enables[DPIR_BIT_STAMP])
            | (events.supply_swap & enables[DPIR_BIT_SUPPLY_SWAP])
            | (events.dog & enables[DPIR_BIT_DOG]);
        flag_any = (flags.tick & enables[DPIR_BIT_TICK])
            | (flags.alarm_one & enables[DPIR_BIT_ALARM_ONE])
            | (flags.alarm_two & enables[DPIR_BIT_ALARM_TWO])
            | (flags.stamp & enables[DPIR_BIT_STAMP])
            | (flags.supply_swap & enables[DPIR_BIT_SUPPLY_SWAP])
            | (flags.dog & enables[DPIR_BIT_DOG]);
        // trim has no flag, so it can never be cleared early
        trig_src_flagged = enables[DPIR_BIT_TICK] | enables[DPIR_BIT_ALARM_ONE]
            | enables[DPIR_BIT_ALARM_TWO] | enables[DPIR_BIT_STAMP]
            | enables[DPIR_BIT_SUPPLY_SWAP] | enables[DPIR_BIT_DOG];
        src_flag_clear = trig_src_flagged & ~flag_any & ~enables[DPIR_BIT_TRIM];
    end

    always_comb
    begin
        s_d = s_q;
        if (enables[DPIR_BIT_LEVEL])
        begin
            // no pulse is kept in level style, so a switch back starts clean
            s_d.pulse = 1'b0;
            s_d.ticks = 2'h0;
        end
        else if (trig)
        begin
            // fresh pulse restarts the release count
            s_d.pulse = 1'b1;
            s_d.ticks = 2'h0;
        end
        else if (s_q.pulse)
        begin
            if (src_flag_clear)
            begin
                s_d.pulse = 1'b0;
            end
            else if (release_tick)
            begin
                // first tick may come at once; second ends it: 1..2 periods
                if (s_q.ticks == 2'h1)
                begin
                    s_d.pulse = 1'b0;
                end
                s_d.ticks = s_q.ticks + 2'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // trigger shows on the pin in the event cycle itself
    always_comb
    begin
        if (enables[DPIR_BIT_LEVEL])
        begin
            irq_active = flag_any | (events.trim & enables[DPIR_BIT_TRIM]);
        end
        else
        begin
            irq_active = trig | s_q.pulse;
        end
    end
endmodule

// >>> dpir_pkg.sv
// Purpose: shared constants and types of the dual pin interrupt router
// Assumes: byte-wide register port, eight-bit addresses
// Notes: bit positions hold for both enable registers
package dpir_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] DPIR_ADDR_PIN_A = 8'h29;
    localparam logic [7:0] DPIR_ADDR_PIN_B = 8'h2A;
    localparam logic [7:0] DPIR_ENABLE_RST = 8'h00;
    // ------------------------------------------------------------
    // enable register fields
    // ------------------------------------------------------------
    localparam int DPIR_BIT_LEVEL = 7;
    localparam int DPIR_BIT_TICK = 6;
    localparam int DPIR_BIT_TRIM = 5;
    localparam int DPIR_BIT_ALARM_ONE = 4;
    localparam int DPIR_BIT_ALARM_TWO = 3;
    localparam int DPIR_BIT_STAMP = 2;
    localparam int DPIR_BIT_SUPPLY_SWAP = 1;
    localparam int DPIR_BIT_DOG = 0;
    // ------------------------------------------------------------
    // pin modes: interrupt output selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] DPIR_FIRST_PIN_MODE_IRQ = 2'h2;
    localparam logic [1:0] DPIR_STAMP_PIN_MODE_IRQ = 2'h3;
    // ------------------------------------------------------------
    // timing: release tick
    // ------------------------------------------------------------
    localparam int DPIR_SYS_HZ = 50000000;
    localparam int DPIR_RELEASE_HZ = 128;
    localparam int DPIR_RELEASE_CYCLES = DPIR_SYS_HZ / DPIR_RELEASE_HZ;

    // one event strobe per source; offset trim has no flag
    typedef struct packed {
        logic tick;
        logic trim;
        logic alarm_one;
        logic alarm_two;
        logic stamp;
        logic supply_swap;
        logic dog;
    } dpir_src_type;

    // flags that software clears elsewhere in the device
    typedef struct packed {
        logic tick;
        logic alarm_one;
        logic alarm_two;
        logic stamp;
        logic supply_swap;
        logic dog;
    } dpir_flag_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpir_reg_req_type;
endpackage

// >>> dpir_release_tick.sv
// Purpose: free-running 128 Hz release tick
// Assumes: sys_clk at 50 MHz
// Notes: counter never stops, so tick is unrelated to any event
`timescale 1ns/1ns
module dpir_release_tick
    import dpir_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // tick
    output logic tick
);
    typedef struct packed {
        logic [18:0] cnt;
        logic tick;
    } dpir_tick_state_type;

    dpir_tick_state_type s_q;
    dpir_tick_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 19'(DPIR_RELEASE_CYCLES - 1))
        begin
            s_d.cnt = 19'h0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 19'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// >>> dpir_top.sv
// Purpose: routes real-time clock events onto two active-low interrupt pins
// Assumes: register port and event sources run on sys_clk
// Notes: pin modes come from the pin configuration register elsewhere
`timescale 1ns/1ns
module dpir_top
    import dpir_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // register port
    input dpir_pkg::dpir_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    // event strobes and flags
    input dpir_pkg::dpir_src_type events,
    input dpir_pkg::dpir_flag_type flags,
    output logic event_monitor_bit,
    // pin modes
    input wire logic [1:0] first_pin_mode,
    input wire logic [1:0] stamp_pin_mode,
    // first pin, open-drain
    output logic irq_out_first_o,
    output logic irq_out_first_oe_n,
    // second pin on stamp_pin, push-pull
    output logic irq_out_second,
    output logic irq_out_second_oe_n
);
    import dpir_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_sync_q <= 2'h0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] rdata;
        logic mon;
        logic a_act;
        logic b_act;
    } dpir_top_state_type;

    dpir_top_state_type s_q;
    dpir_top_state_type s_d;
    logic release_tick;
    logic act_a;
    logic act_b;

    // ------------------------------------------------------------
    // pin generators
    // ------------------------------------------------------------
    dpir_release_tick u_tick
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(release_tick)
    );

    // triggers arrive already qualified by each source block
    dpir_pin_gen u_pin_a
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enables(s_q.en_a),
        .release_tick(release_tick),
        .events(events),
        .flags(flags),
        .irq_active(act_a)
    );

    dpir_pin_gen u_pin_b
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .enables(s_q.en_b),
        .release_tick(release_tick),
        .events(events),
        .flags(flags),
        .irq_active(act_b)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        if (reg_req.wr)
        begin
            if (reg_req.addr == DPIR_ADDR_PIN_A)
            begin
                s_d.en_a = reg_req.wdata;
            end
            else if (reg_req.addr == DPIR_ADDR_PIN_B)
            begin
                s_d.en_b = reg_req.wdata;
            end
        end
        if (reg_req.addr == DPIR_ADDR_PIN_A)
        begin
            s_d.rdata = s_d.en_a;
        end
        else if (reg_req.addr == DPIR_ADDR_PIN_B)
        begin
            s_d.rdata = s_d.en_b;
        end
        else
        begin
            s_d.rdata = 8'h00;
        end
        s_d.mon = |flags;
        s_d.a_act = act_a;
        s_d.b_act = act_b;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '{en_a: DPIR_ENABLE_RST, en_b: DPIR_ENABLE_RST, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic first_sel;
    logic second_sel;

    // combinational so a pulse lands in its event cycle
    always_comb
    begin
        first_sel = (first_pin_mode == DPIR_FIRST_PIN_MODE_IRQ);
        second_sel = (stamp_pin_mode == DPIR_STAMP_PIN_MODE_IRQ);
        irq_out_first_o = 1'b0;
        // open-drain: enable only when pulling low
        irq_out_first_oe_n = ~(first_sel & act_a);
        irq_out_second = ~act_b;
        irq_out_second_oe_n = ~second_sel;
    end

    assign reg_rdata = s_q.rdata;
    assign event_monitor_bit = s_q.mon;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence seq_fire_a;
        events.alarm_one && s_q.en_a[DPIR_BIT_ALARM_ONE] && !s_q.en_a[DPIR_BIT_LEVEL];
    endsequence

    AST_PULSE_NOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_fire_a |-> act_a)
        else $error("pulse not asserted in trigger cycle");
    AST_PULSE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (seq_fire_a ##0 (flags.alarm_one && !release_tick)) ##1 (flags.alarm_one
        && !release_tick && s_q.en_a == $past(s_q.en_a)) |-> act_a)
        else $error("pulse dropped before release tick");
    AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a == 8'h40 && !events.tick && !flags.tick) ##1 (s_q.en_a == 8'h40
        && !events.tick && !flags.tick) |-> !act_a || $past(act_a))
        else $error("pin fired without enabled source");
    AST_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_b[DPIR_BIT_LEVEL] && s_q.en_b[DPIR_BIT_DOG] && flags.dog) |-> act_b)
        else $error("level style ignores enabled flag");
    AST_LEVEL_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_b == 8'h81 && !flags.dog) |-> !act_b)
        else $error("level held after flags cleared");
    AST_OPEN_DRAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !irq_out_first_oe_n |-> (irq_out_first_o == 1'b0 && act_a))
        else $error("first pin driven high or idle");
    AST_MODE_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (first_pin_mode != DPIR_FIRST_PIN_MODE_IRQ) |-> irq_out_first_oe_n)
        else $error("first pin active outside its mode");
    AST_WRITE_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == DPIR_ADDR_PIN_A) |=> s_q.en_a == $past(reg_req.wdata))
        else $error("first enable write lost");
    AST_READ_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!reg_req.wr && reg_req.addr == DPIR_ADDR_PIN_B) |=> reg_rdata == s_q.en_b)
        else $error("second enable readback wrong");
    AST_MON: assert property (@(posedge sys_clk) disable iff (!rst_n)
        flags.dog |=> event_monitor_bit)
        else $error("monitor misses flag");

    // ------------------------------------------------------------
    // checks: second pin and level style
    // ------------------------------------------------------------
    sequence seq_fire_b;
        events.alarm_two && s_q.en_b[DPIR_BIT_ALARM_TWO] && !s_q.en_b[DPIR_BIT_LEVEL];
    endsequence

    AST_PULSE_NOW_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_fire_b |-> act_b)
        else $error("second pin pulse not asserted in trigger cycle");

    AST_PULSE_HOLD_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (seq_fire_b ##0 (flags.alarm_two && !release_tick && !reg_req.wr)) |=> act_b)
        else $error("second pin pulse dropped at once");

    AST_LEVEL_NONE_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a[DPIR_BIT_LEVEL] && s_q.en_a[DPIR_BIT_TICK:DPIR_BIT_DOG] == 7'h00)
        |-> !act_a)
        else $error("first pin level without enabled source");

    AST_LEVEL_NONE_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_b[DPIR_BIT_LEVEL] && s_q.en_b[DPIR_BIT_TICK:DPIR_BIT_DOG] == 7'h00)
        |-> !act_b)
        else $error("second pin level without enabled source");

    AST_LEVEL_DOG_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a[DPIR_BIT_LEVEL] && s_q.en_a[DPIR_BIT_DOG] && flags.dog) |-> act_a)
        else $error("first pin level ignores watchdog flag");

    AST_LEVEL_MASK_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a == 8'h91 && flags == 6'h08) |-> !act_a)
        else $error("first pin level follows disabled flag");

    AST_LEVEL_OFF_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_b == 8'h88 && !flags.alarm_two) |-> !act_b)
        else $error("second pin level held after flag cleared");

    AST_LEVEL_PIN_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (first_pin_mode == DPIR_FIRST_PIN_MODE_IRQ && s_q.en_a[DPIR_BIT_LEVEL]
        && s_q.en_a[DPIR_BIT_ALARM_ONE] && flags.alarm_one) |-> !irq_out_first_oe_n)
        else $error("first pin not pulled low");

    AST_LEVEL_PIN_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (stamp_pin_mode == DPIR_STAMP_PIN_MODE_IRQ && s_q.en_b[DPIR_BIT_LEVEL]
        && s_q.en_b[DPIR_BIT_ALARM_TWO] && flags.alarm_two)
        |-> (!irq_out_second_oe_n && !irq_out_second))
        else $error("second pin not driven low");

    AST_MODE_GATE_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (stamp_pin_mode != DPIR_STAMP_PIN_MODE_IRQ) |-> irq_out_second_oe_n)
        else $error("second pin driven outside its mode");

    // ------------------------------------------------------------
    // checks: release of pulses and levels
    // ------------------------------------------------------------
    // enable bits lined up with the flag word
    logic [5:0] flag_mask_a;
    logic [5:0] flag_mask_b;

    assign flag_mask_a = {s_q.en_a[DPIR_BIT_TICK], s_q.en_a[DPIR_BIT_ALARM_ONE:DPIR_BIT_DOG]};
    assign flag_mask_b = {s_q.en_b[DPIR_BIT_TICK], s_q.en_b[DPIR_BIT_ALARM_ONE:DPIR_BIT_DOG]};

    // pulse style, trim off, every enabled flag and strobe low
    sequence seq_quiet_a;
        !s_q.en_a[DPIR_BIT_LEVEL] && !s_q.en_a[DPIR_BIT_TRIM]
        && s_q.en_a[DPIR_BIT_TICK:DPIR_BIT_DOG] != 7'h00
        && (flag_mask_a & flags) == 6'h00
        && (events & s_q.en_a[DPIR_BIT_TICK:DPIR_BIT_DOG]) == 7'h00;
    endsequence

    // clearing the flags must cut the pulse within one cycle
    AST_EARLY_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_quiet_a ##1 seq_quiet_a |-> !act_a)
        else $error("pulse outlives cleared flags");

    // trim has no flag, so only the release tick may end its pulse
    AST_TRIM_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!reg_req.wr && !s_q.en_a[DPIR_BIT_LEVEL] && s_q.en_a[DPIR_BIT_TRIM] && act_a
        && !release_tick) |=> act_a)
        else $error("trim pulse ended without release tick");

    AST_TRIM_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a[DPIR_BIT_LEVEL] && s_q.en_a[DPIR_BIT_TICK:DPIR_BIT_DOG] == 7'h20
        && !events.trim) |-> !act_a)
        else $error("trim holds a level");

    AST_LEVEL_TRACK_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_a[DPIR_BIT_LEVEL] && s_q.a_act && (flag_mask_a & flags) == 6'h00
        && !events.trim) |-> !act_a)
        else $error("first pin level not released");

    AST_LEVEL_TRACK_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_q.en_b[DPIR_BIT_LEVEL] && s_q.b_act && (flag_mask_b & flags) == 6'h00
        && !events.trim) |-> !act_b)
        else $error("second pin level not released");

    // ------------------------------------------------------------
    // checks: register port and monitor
    // ------------------------------------------------------------
    AST_READ_A: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!reg_req.wr && reg_req.addr == DPIR_ADDR_PIN_A) |=> reg_rdata == s_q.en_a)
        else $error("first enable readback wrong");

    AST_WRITE_B: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr == DPIR_ADDR_PIN_B) |=> s_q.en_b == $past(reg_req.wdata))
        else $error("second enable write lost");

    AST_READ_OTHER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req.addr != DPIR_ADDR_PIN_A && reg_req.addr != DPIR_ADDR_PIN_B)
        |=> reg_rdata == 8'h00)
        else $error("unmapped address reads nonzero");

    AST_WRITE_OTHER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_req.wr && reg_req.addr != DPIR_ADDR_PIN_A && reg_req.addr != DPIR_ADDR_PIN_B)
        |=> (s_q.en_a == $past(s_q.en_a) && s_q.en_b == $past(s_q.en_b)))
        else $error("unmapped write changed an enable");

    AST_MON_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (flags == 6'h00) |=> !event_monitor_bit)
        else $error("monitor set without flags");
endmodule

// >>> dpir_top_tb.sv
// Purpose: self-checking bench of the dual pin interrupt router
// Assumes: full 128 Hz pulse length is too long to wait out here
// Notes: pulses are ended by flag clear or by reset instead
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
            errors++; \
        end \
    end
module dpir_top_tb;
    import dpir_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic nrst;
    dpir_reg_req_type reg_req;
    logic [7:0] reg_rdata;
    dpir_src_type events;
    dpir_flag_type flags;
    logic event_monitor_bit;
    logic [1:0] first_pin_mode;
    logic [1:0] stamp_pin_mode;
    logic a_o, a_oe_n, b_o, b_oe_n, line_a_n, line_b_n;
    int errors = 0;
    int n_tests = 0;

    always #10 sys_clk = ~sys_clk;

    dpir_top i_dpir_top (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .events(events), .flags(flags),
        .event_monitor_bit(event_monitor_bit), .first_pin_mode(first_pin_mode),
        .stamp_pin_mode(stamp_pin_mode), .irq_out_first_o(a_o),
        .irq_out_first_oe_n(a_oe_n), .irq_out_second(b_o), .irq_out_second_oe_n(b_oe_n));

    dpir_host_model i_dpir_host_model (.sys_clk(sys_clk), .first_o(a_o),
        .first_oe_n(a_oe_n), .second_o(b_o), .second_oe_n(b_oe_n),
        .line_first_n(line_a_n), .line_second_n(line_b_n));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
        wait_cyc(1);
        `CHK("reg_rdata", e, reg_rdata);
    endtask

    task automatic chk_pins(input logic ea, input logic eb);
        `CHK("line_first", ea, line_a_n);
        `CHK("line_second", eb, line_b_n);
    endtask

    // flag bit that belongs to an enable bit; trim has none
    function automatic dpir_flag_type flag_of(input int i);
        return (i == 6) ? 6'h20 : (i == 5) ? 6'h00 : 6'(1 << i);
    endfunction

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial
    begin
        #(20000 * 20);
        errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        reg_req = '0;
        events = '0;
        flags = '0;
        first_pin_mode = DPIR_FIRST_PIN_MODE_IRQ;
        stamp_pin_mode = DPIR_STAMP_PIN_MODE_IRQ;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_cyc(4);
        reg_read(DPIR_ADDR_PIN_A, DPIR_ENABLE_RST);
        reg_read(DPIR_ADDR_PIN_B, DPIR_ENABLE_RST);
        reg_write(DPIR_ADDR_PIN_A, 8'hA5);
        reg_write(DPIR_ADDR_PIN_B, 8'h5A);
        reg_write(8'h2B, 8'hFF);
        reg_read(8'h2B, 8'h00);
        reg_read(DPIR_ADDR_PIN_A, 8'hA5);
        reg_read(DPIR_ADDR_PIN_B, 8'h5A);
        reg_write(DPIR_ADDR_PIN_A, 8'h00);
        reg_write(DPIR_ADDR_PIN_B, 8'h00);
        // pulse style, each source but trim alone on each pin
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 7; i++)
            begin
                if (i == 5)
                    continue;
                reg_write(p ? DPIR_ADDR_PIN_B : DPIR_ADDR_PIN_A, 8'(1 << i));
                @(posedge sys_clk);
                events <= 7'(1 << i);
                flags <= flag_of(i);
                #1;
                chk_pins(1'(p), 1'(!p));
                @(posedge sys_clk);
                events <= '0;
                #1;
                chk_pins(1'(p), 1'(!p));
                @(posedge sys_clk);
                flags <= '0;
                wait_cyc(3);
                chk_pins(1'b1, 1'b1);
                reg_write(p ? DPIR_ADDR_PIN_B : DPIR_ADDR_PIN_A, 8'h00);
            end
        // pin modes not selecting interrupt output
        reg_write(DPIR_ADDR_PIN_A, 8'h01);
        reg_write(DPIR_ADDR_PIN_B, 8'h01);
        @(posedge sys_clk);
        first_pin_mode <= 2'h0;
        stamp_pin_mode <= 2'h0;
        events <= 7'h01;
        flags <= 6'h01;
        #1;
        `CHK("first_oe_n", 1'b1, a_oe_n);
        `CHK("second_oe_n", 1'b1, b_oe_n);
        @(posedge sys_clk);
        events <= '0;
        flags <= '0;
        first_pin_mode <= DPIR_FIRST_PIN_MODE_IRQ;
        stamp_pin_mode <= DPIR_STAMP_PIN_MODE_IRQ;
        wait_cyc(3);
        chk_pins(1'b1, 1'b1);
        // monitor sees every flag, level pins with no source see none
        reg_write(DPIR_ADDR_PIN_A, 8'h80);
        reg_write(DPIR_ADDR_PIN_B, 8'h80);
        @(posedge sys_clk);
        flags <= 6'h3F;
        wait_cyc(2);
        `CHK("monitor", 1'b1, event_monitor_bit);
        chk_pins(1'b1, 1'b1);
        @(posedge sys_clk);
        flags <= '0;
        wait_cyc(2);
        `CHK("monitor", 1'b0, event_monitor_bit);
        // level style
        reg_write(DPIR_ADDR_PIN_A, 8'h91);
        reg_write(DPIR_ADDR_PIN_B, 8'h88);
        @(posedge sys_clk);
        flags <= 6'h08;
        #1;
        chk_pins(1'b1, 1'b0);
        @(posedge sys_clk);
        flags <= 6'h19;
        #1;
        chk_pins(1'b0, 1'b0);
        // software clears both alarm flags, then the watchdog flag
        @(posedge sys_clk);
        flags <= 6'h01;
        #1;
        chk_pins(1'b0, 1'b1);
        @(posedge sys_clk);
        flags <= '0;
        #1;
        chk_pins(1'b1, 1'b1);
        // trim in level style never holds
        reg_write(DPIR_ADDR_PIN_A, 8'hA0);
        @(posedge sys_clk);
        events <= 7'h20;
        #1;
        chk_pins(1'b0, 1'b1);
        @(posedge sys_clk);
        events <= '0;
        wait_cyc(1);
        chk_pins(1'b1, 1'b1);
        // trim pulse cannot be cut short; reset ends it
        reg_write(DPIR_ADDR_PIN_A, 8'h20);
        #1;
        chk_pins(1'b1, 1'b1);
        @(posedge sys_clk);
        events <= 7'h20;
        #1;
        chk_pins(1'b0, 1'b1);
        @(posedge sys_clk);
        events <= '0;
        wait_cyc(20);
        chk_pins(1'b0, 1'b1);
        @(posedge sys_clk);
        nrst <= 1'b0;
        #1;
        chk_pins(1'b1, 1'b1);
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_cyc(4);
        reg_read(DPIR_ADDR_PIN_A, DPIR_ENABLE_RST);
        reg_read(DPIR_ADDR_PIN_B, DPIR_ENABLE_RST);
        test_done();
    end
endmodule
